// ### hdl/rctr_tuning_regs.sv
// ripple-count tuning register bank with decoded configuration outputs
module rctr_tuning_regs #(
	parameter int NUM_W = 5,
	parameter int FRAC_W = 9
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	output logic [7:0] reg_rd_data,
	output logic reg_rd_valid,
	input wire logic correction_module_off,
	output logic [3:0] bandpass_inverse_q,
	output logic bandpass_q_off_recommended,
	output logic correction_enable,
	output logic correction_pulse_stop,
	output logic [2:0] mechanical_response_filter,
	output logic [5:0] extra_ripple_window_pct,
	output logic [5:0] missed_ripple_window_pct,
	output logic [4:0] proportional_numerator,
	output logic [2:0] proportional_divider,
	output logic [NUM_W+FRAC_W-1:0] proportional_gain,
	output logic proportional_divider_bad,
	output logic [4:0] integral_numerator,
	output logic [2:0] integral_divider,
	output logic [NUM_W+FRAC_W-1:0] integral_gain,
	output logic integral_divider_bad
);
	localparam int GW = NUM_W + FRAC_W;

	// the numerator field is five bits wide in the register
	if (NUM_W != rctr_pkg::NUM_W) begin : g_bad_num
		$error("rctr_tuning_regs: NUM_W must match the numerator field");
	end

	////////////////////////////////////////////////////////////////////////////////
	// register storage
	logic [7:0] bandpass_damping_cfg_reg;
	logic [7:0] bandpass_damping_cfg_next;
	logic [7:0] error_correction_cfg_reg;
	logic [7:0] error_correction_cfg_next;
	logic [7:0] speed_loop_proportional_cfg_reg;
	logic [7:0] speed_loop_proportional_cfg_next;
	logic [7:0] speed_loop_integral_cfg_reg;
	logic [7:0] speed_loop_integral_cfg_next;

	// address decode
	wire hit_damping = (reg_addr == rctr_pkg::BANDPASS_DAMPING_CFG_OFS);
	wire hit_correction = (reg_addr == rctr_pkg::ERROR_CORRECTION_CFG_OFS);
	wire hit_proportional = (reg_addr == rctr_pkg::SPEED_LOOP_PROPORTIONAL_CFG_OFS);
	wire hit_integral = (reg_addr == rctr_pkg::SPEED_LOOP_INTEGRAL_CFG_OFS);
	wire hit_any = hit_damping | hit_correction | hit_proportional | hit_integral;

	// full byte stored, reserved nibble included; unmapped writes dropped
	assign bandpass_damping_cfg_next =
		(reg_wr_en && hit_damping) ? reg_wr_data : bandpass_damping_cfg_reg;
	assign error_correction_cfg_next =
		(reg_wr_en && hit_correction) ? reg_wr_data : error_correction_cfg_reg;
	assign speed_loop_proportional_cfg_next =
		(reg_wr_en && hit_proportional) ? reg_wr_data : speed_loop_proportional_cfg_reg;
	assign speed_loop_integral_cfg_next =
		(reg_wr_en && hit_integral) ? reg_wr_data : speed_loop_integral_cfg_reg;

	// register update with documented reset values
	always_ff @(posedge clock) begin
		if (!nrst) begin
			bandpass_damping_cfg_reg <= rctr_pkg::BANDPASS_DAMPING_CFG_RST;
			error_correction_cfg_reg <= rctr_pkg::ERROR_CORRECTION_CFG_RST;
			speed_loop_proportional_cfg_reg <= rctr_pkg::SPEED_LOOP_PROPORTIONAL_CFG_RST;
			speed_loop_integral_cfg_reg <= rctr_pkg::SPEED_LOOP_INTEGRAL_CFG_RST;
		end else begin
			bandpass_damping_cfg_reg <= bandpass_damping_cfg_next;
			error_correction_cfg_reg <= error_correction_cfg_next;
			speed_loop_proportional_cfg_reg <= speed_loop_proportional_cfg_next;
			speed_loop_integral_cfg_reg <= speed_loop_integral_cfg_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path
	logic [7:0] rd_data_reg;
	logic rd_valid_reg;
	wire [7:0] rd_mux =
		hit_damping ? bandpass_damping_cfg_reg :
		hit_correction ? error_correction_cfg_reg :
		hit_proportional ? speed_loop_proportional_cfg_reg :
		hit_integral ? speed_loop_integral_cfg_reg :
		rctr_pkg::READ_UNMAPPED_VALUE;

	// read data captured one cycle after the request
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rd_data_reg <= 8'h00;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_data_reg <= reg_rd_en ? rd_mux : rd_data_reg;
			rd_valid_reg <= reg_rd_en;
		end
	end

	assign reg_rd_data = rd_data_reg;
	assign reg_rd_valid = rd_valid_reg;

	////////////////////////////////////////////////////////////////////////////////
	// field extraction
	wire [3:0] inv_q_fld = bandpass_damping_cfg_reg[rctr_pkg::INV_Q_LSB +: rctr_pkg::INV_Q_W];
	wire pulse_stop_fld = error_correction_cfg_reg[rctr_pkg::PULSE_STOP_BIT];
	wire [2:0] mech_fld =
		error_correction_cfg_reg[rctr_pkg::MECH_FLT_LSB +: rctr_pkg::MECH_FLT_W];
	wire [1:0] extra_fld = error_correction_cfg_reg[rctr_pkg::EXTRA_WIN_LSB +: rctr_pkg::WIN_W];
	wire [1:0] missed_fld =
		error_correction_cfg_reg[rctr_pkg::MISSED_WIN_LSB +: rctr_pkg::WIN_W];
	wire [4:0] kp_num_fld = speed_loop_proportional_cfg_reg[rctr_pkg::NUM_LSB +: rctr_pkg::NUM_W];
	wire [2:0] proportional_divider_fld = speed_loop_proportional_cfg_reg[rctr_pkg::DIV_LSB +: rctr_pkg::DIV_W];
	wire [4:0] ki_num_fld = speed_loop_integral_cfg_reg[rctr_pkg::NUM_LSB +: rctr_pkg::NUM_W];
	wire [2:0] integral_divider_fld = speed_loop_integral_cfg_reg[rctr_pkg::DIV_LSB +: rctr_pkg::DIV_W];

	// window code to percent: 20 plus 10 per step
	wire [5:0] extra_pct =
		6'(rctr_pkg::WIN_BASE_PCT + 6'(rctr_pkg::WIN_STEP_PCT * extra_fld));
	wire [5:0] missed_pct =
		6'(rctr_pkg::WIN_BASE_PCT + 6'(rctr_pkg::WIN_STEP_PCT * missed_fld));

	// effective gains from numerator and divider code
	logic [GW-1:0] kp_gain;
	logic [GW-1:0] ki_gain;
	logic kp_bad;
	logic ki_bad;

	rctr_gain_calc #(.NUM_W(NUM_W), .FRAC_W(FRAC_W)) u_kp_gain (
		.numerator(kp_num_fld),
		.divider_code(proportional_divider_fld),
		.gain(kp_gain),
		.reserved_code(kp_bad)
	);

	rctr_gain_calc #(.NUM_W(NUM_W), .FRAC_W(FRAC_W)) u_ki_gain (
		.numerator(ki_num_fld),
		.divider_code(integral_divider_fld),
		.gain(ki_gain),
		.reserved_code(ki_bad)
	);

	////////////////////////////////////////////////////////////////////////////////
	// registered configuration outputs
	logic [3:0] inv_q_reg;
	logic q_off_rec_reg;
	logic corr_en_reg;
	logic pulse_stop_reg;
	logic [2:0] mech_reg;
	logic [5:0] extra_pct_reg;
	logic [5:0] missed_pct_reg;
	logic [4:0] kp_num_reg;
	logic [2:0] proportional_divider_reg;
	logic [GW-1:0] kp_gain_reg;
	logic kp_bad_reg;
	logic [4:0] ki_num_reg;
	logic [2:0] integral_divider_reg;
	logic [GW-1:0] ki_gain_reg;
	logic ki_bad_reg;

	// module-off overrides correction regardless of pulse stop
	wire corr_en_next = !correction_module_off;
	wire q_off_next = (inv_q_fld != rctr_pkg::INV_Q_RECOMMENDED);

	// one pipeline stage toward the ripple engine
	always_ff @(posedge clock) begin
		if (!nrst) begin
			inv_q_reg <= rctr_pkg::INV_Q_RECOMMENDED;
			q_off_rec_reg <= 1'b0;
			corr_en_reg <= 1'b0;
			pulse_stop_reg <= 1'b0;
			mech_reg <= 3'h4;
			extra_pct_reg <= 6'h1E;
			missed_pct_reg <= 6'h1E;
			kp_num_reg <= 5'h01;
			proportional_divider_reg <= 3'h1;
			kp_gain_reg <= '0;
			kp_bad_reg <= 1'b0;
			ki_num_reg <= 5'h01;
			integral_divider_reg <= 3'h1;
			ki_gain_reg <= '0;
			ki_bad_reg <= 1'b0;
		end else begin
			inv_q_reg <= inv_q_fld;
			q_off_rec_reg <= q_off_next;
			corr_en_reg <= corr_en_next;
			pulse_stop_reg <= pulse_stop_fld;
			mech_reg <= mech_fld;
			extra_pct_reg <= extra_pct;
			missed_pct_reg <= missed_pct;
			kp_num_reg <= kp_num_fld;
			proportional_divider_reg <= proportional_divider_fld;
			kp_gain_reg <= kp_gain;
			kp_bad_reg <= kp_bad;
			ki_num_reg <= ki_num_fld;
			integral_divider_reg <= integral_divider_fld;
			ki_gain_reg <= ki_gain;
			ki_bad_reg <= ki_bad;
		end
	end

	// output wiring
	assign bandpass_inverse_q = inv_q_reg;
	assign bandpass_q_off_recommended = q_off_rec_reg;
	assign correction_enable = corr_en_reg;
	assign correction_pulse_stop = pulse_stop_reg;
	assign mechanical_response_filter = mech_reg;
	assign extra_ripple_window_pct = extra_pct_reg;
	assign missed_ripple_window_pct = missed_pct_reg;
	assign proportional_numerator = kp_num_reg;
	assign proportional_divider = proportional_divider_reg;
	assign proportional_gain = kp_gain_reg;
	assign proportional_divider_bad = kp_bad_reg;
	assign integral_numerator = ki_num_reg;
	assign integral_divider = integral_divider_reg;
	assign integral_gain = ki_gain_reg;
	assign integral_divider_bad = ki_bad_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	inv_q_write_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(reg_wr_en && hit_damping) ##1 !(reg_wr_en && hit_damping)
			|=> bandpass_inverse_q == $past(reg_wr_data[7:4], 2))
		else $error("inverse Q output does not follow damping write");

	inv_q_reset_a: assert property (
		@(posedge clock)
		!nrst ##1 (nrst && !reg_wr_en) |=> bandpass_inverse_q == 4'h6)
		else $error("inverse Q not six after reset");

	pulse_stop_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(reg_wr_en && hit_correction) ##1 !(reg_wr_en && hit_correction)
			|=> correction_pulse_stop == $past(reg_wr_data[7], 2))
		else $error("pulse stop output does not follow write");

	mech_filter_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(reg_wr_en && hit_correction) ##1 !(reg_wr_en && hit_correction)
			|=> mechanical_response_filter == $past(reg_wr_data[6:4], 2))
		else $error("mechanical filter output does not follow write");

	extra_window_a: assert property (
		@(posedge clock) disable iff (!nrst)
		##1 1'b1 |-> extra_ripple_window_pct == 6'd20 + 6'd10 * $past(extra_fld))
		else $error("extra-ripple window percent wrong");

	missed_window_a: assert property (
		@(posedge clock) disable iff (!nrst)
		##1 1'b1 |-> missed_ripple_window_pct == 6'd20 + 6'd10 * $past(missed_fld))
		else $error("missed-ripple window percent wrong");

	kp_div16_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(proportional_divider_fld == 3'h5) |=> proportional_gain == GW'({$past(kp_num_fld), 5'h00}))
		else $error("proportional gain wrong for divisor 16");

	kp_unity_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(proportional_divider_fld == 3'h6) |=> proportional_gain == GW'({$past(kp_num_fld), 9'h000}))
		else $error("proportional gain wrong for divisor 1");

	ki_div32_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(integral_divider_fld == 3'h0) |=> integral_gain == GW'({$past(ki_num_fld), 4'h0}))
		else $error("integral gain wrong for divisor 32");

	ki_div512_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(integral_divider_fld == 3'h4) |=> integral_gain == GW'($past(ki_num_fld)))
		else $error("integral gain wrong for divisor 512");

	num_reset_a: assert property (
		@(posedge clock)
		!nrst ##1 (nrst && !reg_wr_en) |=> proportional_numerator == 5'h01
			&& integral_numerator == 5'h01 && proportional_divider == 3'h1)
		else $error("numerators or divider not at reset value");

	module_off_a: assert property (
		@(posedge clock) disable iff (!nrst)
		correction_module_off |=> !correction_enable)
		else $error("correction still enabled while module off");

	readback_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(reg_wr_en && hit_any) ##1 (reg_rd_en && !reg_wr_en
			&& reg_addr == $past(reg_addr)) |=> reg_rd_valid
			&& reg_rd_data == $past(reg_wr_data, 2))
		else $error("read does not return last written value");

	unmapped_read_a: assert property (
		@(posedge clock) disable iff (!nrst)
		(reg_rd_en && !hit_any) |=> reg_rd_valid && reg_rd_data == 8'h00)
		else $error("unmapped read not zero");
endmodule : rctr_tuning_regs

// ### common/rctr_pkg.sv
// Contract
// - damping high nibble sets bandpass inverse Q, reset 6
// - pulse stop clear keeps correction always active
// - mechanical response field, reset four, sets lowpass
// - extra-ripple window codes 20..50 percent, reset 01b
// - missed-ripple window codes 20..50 percent, reset 01b
// - proportional divider codes map to 32..512,16,1
// - proportional gain equals numerator over divisor
// - proportional numerator low five bits, resets one
// - integral divider codes map to 32..512,16,1
// - integral gain equals numerator over divisor
// - integral numerator low five bits, resets one
// - module-off input disables whole correction independently
package rctr_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] BANDPASS_DAMPING_CFG_OFS = 8'h16;
	localparam logic [7:0] ERROR_CORRECTION_CFG_OFS = 8'h17;
	localparam logic [7:0] SPEED_LOOP_PROPORTIONAL_CFG_OFS = 8'h18;
	localparam logic [7:0] SPEED_LOOP_INTEGRAL_CFG_OFS = 8'h19;
	// reset values
	localparam logic [7:0] BANDPASS_DAMPING_CFG_RST = 8'h60;
	localparam logic [7:0] ERROR_CORRECTION_CFG_RST = 8'h45;
	localparam logic [7:0] SPEED_LOOP_PROPORTIONAL_CFG_RST = 8'h21;
	localparam logic [7:0] SPEED_LOOP_INTEGRAL_CFG_RST = 8'h21;
	localparam logic [7:0] READ_UNMAPPED_VALUE = 8'h00;
	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int INV_Q_LSB = 4;
	localparam int INV_Q_W = 4;
	localparam logic [3:0] INV_Q_RECOMMENDED = 4'h6;
	localparam int PULSE_STOP_BIT = 7;
	localparam int MECH_FLT_LSB = 4;
	localparam int MECH_FLT_W = 3;
	localparam int EXTRA_WIN_LSB = 2;
	localparam int MISSED_WIN_LSB = 0;
	localparam int WIN_W = 2;
	localparam int DIV_LSB = 5;
	localparam int DIV_W = 3;
	localparam int NUM_LSB = 0;
	localparam int NUM_W = 5;
	////////////////////////////////////////////////////////////////////////////////
	// window percentage coding: base plus step per code
	localparam int PCT_W = 6;
	localparam logic [5:0] WIN_BASE_PCT = 6'h14;
	localparam logic [5:0] WIN_STEP_PCT = 6'h0A;
	////////////////////////////////////////////////////////////////////////////////
	// divider codes and the left shift giving gain in units of 1/512
	localparam int GAIN_FRAC_W = 9;
	localparam logic [2:0] DIV_32 = 3'h0;
	localparam logic [2:0] DIV_64 = 3'h1;
	localparam logic [2:0] DIV_128 = 3'h2;
	localparam logic [2:0] DIV_256 = 3'h3;
	localparam logic [2:0] DIV_512 = 3'h4;
	localparam logic [2:0] DIV_16 = 3'h5;
	localparam logic [2:0] DIV_1 = 3'h6;
	localparam logic [2:0] DIV_RESERVED = 3'h7;
	localparam logic [3:0] SHIFT_32 = 4'h4;
	localparam logic [3:0] SHIFT_64 = 4'h3;
	localparam logic [3:0] SHIFT_128 = 4'h2;
	localparam logic [3:0] SHIFT_256 = 4'h1;
	localparam logic [3:0] SHIFT_512 = 4'h0;
	localparam logic [3:0] SHIFT_16 = 4'h5;
	localparam logic [3:0] SHIFT_1 = 4'h9;
endpackage : rctr_pkg

// ### hdl/rctr_gain_calc.sv
// gain = numerator / divisor, as a fixed-point value in units of 1/512 (GAIN_FRAC_W fraction bits, whatever FRAC_W is)
module rctr_gain_calc #(
	parameter int NUM_W = 5,
	parameter int FRAC_W = 9
) (
	input wire logic [NUM_W-1:0] numerator,
	input wire logic [2:0] divider_code,
	output logic [NUM_W+FRAC_W-1:0] gain,
	output logic reserved_code
);
	localparam int GW = NUM_W + FRAC_W;

	// a divisor of 1, shifted left by 9, must still fit in the gain width
	if (FRAC_W < rctr_pkg::GAIN_FRAC_W || NUM_W < 1) begin : g_bad_width
		$error("rctr_gain_calc: FRAC_W too small or NUM_W zero");
	end

	logic [3:0] shift;

	// divider code to shift amount
	always_comb begin
		unique case (divider_code)
			rctr_pkg::DIV_32: shift = rctr_pkg::SHIFT_32;
			rctr_pkg::DIV_64: shift = rctr_pkg::SHIFT_64;
			rctr_pkg::DIV_128: shift = rctr_pkg::SHIFT_128;
			rctr_pkg::DIV_256: shift = rctr_pkg::SHIFT_256;
			rctr_pkg::DIV_512: shift = rctr_pkg::SHIFT_512;
			rctr_pkg::DIV_16: shift = rctr_pkg::SHIFT_16;
			rctr_pkg::DIV_1: shift = rctr_pkg::SHIFT_1;
			default: shift = rctr_pkg::SHIFT_512;
		endcase
	end

	// reserved code gives zero gain so the loop stays passive
	assign reserved_code = (divider_code == rctr_pkg::DIV_RESERVED);
	assign gain = reserved_code ? '0 : GW'(GW'(numerator) << shift);
endmodule : rctr_gain_calc

// ### verif/rctr_host_model.sv
////////////////////////////////////////////////////////////////////////////////
// host side of the register strobes, driven at falling edges
module rctr_host_model (
	input wire logic clock,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wr_data,
	input wire logic [7:0] reg_rd_data,
	input wire logic reg_rd_valid
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle bus at time zero
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wr_data = 8'h00;
	end

	// one write strobe, held across exactly one rising edge
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clock);
		reg_wr_en = 1'b1;
		reg_addr = addr;
		reg_wr_data = data;
		@(negedge clock);
		reg_wr_en = 1'b0;
		reg_addr = ~addr; // released bus never keeps the stale value
		reg_wr_data = ~data;
	endtask : wr

	// one read strobe, answer taken in the cycle after the strobe edge
	task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic vld);
		@(negedge clock);
		reg_rd_en = 1'b1;
		reg_addr = addr;
		@(negedge clock);
		data = reg_rd_data;
		vld = reg_rd_valid;
		reg_rd_en = 1'b0;
		reg_addr = ~addr;
	endtask : rd

	// write then read of the same place on the next edge, no idle cycle between
	task automatic wr_rd(input logic [7:0] addr, input logic [7:0] data,
		output logic [7:0] rdata, output logic vld);
		@(negedge clock);
		reg_wr_en = 1'b1;
		reg_addr = addr;
		reg_wr_data = data;
		@(negedge clock);
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b1;
		reg_wr_data = ~data;
		@(negedge clock);
		rdata = reg_rd_data;
		vld = reg_rd_valid;
		reg_rd_en = 1'b0;
		reg_addr = ~addr;
	endtask : wr_rd

	// damping write that keeps the filter inverse Q at its recommended value
	task automatic wr_damping(input logic [3:0] low);
		wr(8'h16, {rctr_pkg::INV_Q_RECOMMENDED, low});
	endtask : wr_damping
endmodule : rctr_host_model

// ### verif/ripple_count_tuning_regs_tb.sv
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

////////////////////////////////////////////////////////////////////////////////
module ripple_count_tuning_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int GW = 14;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic correction_module_off = 1'b0;
	logic reg_wr_en, reg_rd_en, reg_rd_valid;
	logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
	logic [3:0] bandpass_inverse_q;
	logic bandpass_q_off_recommended, correction_enable, correction_pulse_stop;
	logic [2:0] mechanical_response_filter, proportional_divider, integral_divider;
	logic [5:0] extra_ripple_window_pct, missed_ripple_window_pct;
	logic [4:0] proportional_numerator, integral_numerator;
	logic [GW-1:0] proportional_gain, integral_gain;
	logic proportional_divider_bad, integral_divider_bad;
	int error_cnt = 0;
	int check_count = 0;
	logic [31:0] rng_state = 32'h39DC1E88;

	// clock, 10 ns period
	always #5 clock = ~clock;

	rctr_host_model host (.clock(clock), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
		.reg_rd_valid(reg_rd_valid));

	rctr_tuning_regs #(.NUM_W(5), .FRAC_W(9)) dut (.clock(clock), .nrst(nrst),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
		.correction_module_off(correction_module_off), .bandpass_inverse_q(bandpass_inverse_q),
		.bandpass_q_off_recommended(bandpass_q_off_recommended),
		.correction_enable(correction_enable), .correction_pulse_stop(correction_pulse_stop),
		.mechanical_response_filter(mechanical_response_filter),
		.extra_ripple_window_pct(extra_ripple_window_pct),
		.missed_ripple_window_pct(missed_ripple_window_pct),
		.proportional_numerator(proportional_numerator),
		.proportional_divider(proportional_divider), .proportional_gain(proportional_gain),
		.proportional_divider_bad(proportional_divider_bad),
		.integral_numerator(integral_numerator), .integral_divider(integral_divider),
		.integral_gain(integral_gain), .integral_divider_bad(integral_divider_bad));

	////////////////////////////////////////////////////////////////////////////////
	// xorshift source with fixed start
	function automatic logic [31:0] xs();
		rng_state ^= rng_state << 13;
		rng_state ^= rng_state >> 17;
		rng_state ^= rng_state << 5;
		return rng_state;
	endfunction : xs

	// numerator over divisor in units of 1/512, zero for the unused code
	function automatic logic [GW-1:0] gain_exp(input logic [4:0] num, input logic [2:0] code);
		logic [9:0] div;
		case (code)
			3'h0: div = 10'h020;
			3'h1: div = 10'h040;
			3'h2: div = 10'h080;
			3'h3: div = 10'h100;
			3'h4: div = 10'h200;
			3'h5: div = 10'h010;
			3'h6: div = 10'h001;
			default: div = 10'h000;
		endcase
		return (div == 10'h000) ? '0 : GW'(num) * GW'(10'h200 / div);
	endfunction : gain_exp

	// window percentage, 20 plus 10 per code step
	function automatic logic [5:0] win_exp(input logic [1:0] c);
		return 6'h14 + 6'h0A * {4'h0, c};
	endfunction : win_exp

	////////////////////////////////////////////////////////////////////////////////
	// read one register and compare against the expected byte
	task automatic chk_rd(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		host.rd(addr, d, v);
		`CHK(v, 1'b1);
		`CHK(d, exp);
	endtask : chk_rd

	// outputs and stored bytes right after reset
	task automatic check_defaults();
		`CHK(bandpass_inverse_q, 4'h6);
		`CHK(bandpass_q_off_recommended, 1'b0);
		`CHK(correction_pulse_stop, 1'b0);
		`CHK(mechanical_response_filter, 3'h4);
		`CHK(extra_ripple_window_pct, win_exp(2'h1));
		`CHK(missed_ripple_window_pct, win_exp(2'h1));
		`CHK(proportional_divider, 3'h1);
		`CHK(proportional_gain, gain_exp(5'h01, 3'h1));
		`CHK(proportional_numerator, 5'h01);
		`CHK(integral_divider, 3'h1);
		`CHK(integral_gain, gain_exp(5'h01, 3'h1));
		`CHK(integral_numerator, 5'h01);
		chk_rd(8'h16, {4'h6, 4'h0});
		chk_rd(8'h17, {1'b0, 3'h4, 2'h1, 2'h1});
		chk_rd(8'h18, {3'h1, 5'h01});
		chk_rd(8'h19, {3'h1, 5'h01});
	endtask : check_defaults

	// reset held ten cycles, then defaults checked
	task automatic do_reset();
		nrst = 1'b0;
		repeat (10) @(negedge clock);
		`CHK(reg_rd_valid, 1'b0);
		nrst = 1'b1;
		@(negedge clock);
		check_defaults();
	endtask : do_reset

	// verdict and end of run
	task automatic final_report();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake
	initial begin
		#200us;
		error_cnt++;
		final_report();
	end

	// main sequence
	initial begin
		logic [4:0] num;
		logic [3:0] low;
		logic [7:0] v17;
		logic off;
		logic [7:0] wv;
		logic [7:0] rd_b;
		logic rd_v;
		do_reset();
		// unmapped places: writes ignored, reads give zero
		host.wr(8'h1A, 8'hFF);
		host.wr(8'h15, 8'hFF);
		chk_rd(8'h15, 8'h00);
		check_defaults();
		// every divider code on both gain registers
		for (int c = 0; c < 8; c++) begin
			num = (c == 6) ? 5'h1F : 5'(xs());
			host.wr(8'h18, {3'(c), num});
			host.wr(8'h19, {3'(c), ~num});
			@(negedge clock);
			`CHK(proportional_divider, 3'(c));
			`CHK(proportional_numerator, num);
			`CHK(proportional_gain, gain_exp(num, 3'(c)));
			`CHK(proportional_divider_bad, (c == 7));
			`CHK(integral_divider, 3'(c));
			`CHK(integral_numerator, ~num);
			`CHK(integral_gain, gain_exp(~num, 3'(c)));
			`CHK(integral_divider_bad, (c == 7));
			chk_rd(8'h18, {3'(c), num});
			chk_rd(8'h19, {3'(c), ~num});
		end
		// every window code pair with random stop bit and response filter
		for (int w = 0; w < 16; w++) begin
			v17 = 8'(xs() & 32'hF0) | 8'(w);
			host.wr(8'h17, v17);
			@(negedge clock);
			`CHK(correction_pulse_stop, v17[7]);
			`CHK(mechanical_response_filter, v17[6:4]);
			`CHK(extra_ripple_window_pct, win_exp(v17[3:2]));
			`CHK(missed_ripple_window_pct, win_exp(v17[1:0]));
			chk_rd(8'h17, v17);
		end
		// damping register, recommended and deliberately altered inverse Q
		low = 4'(xs());
		host.wr_damping(low);
		@(negedge clock);
		`CHK(bandpass_inverse_q, 4'h6);
		`CHK(bandpass_q_off_recommended, 1'b0);
		chk_rd(8'h16, {4'h6, low});
		host.wr(8'h16, {4'h3, ~low});
		@(negedge clock);
		`CHK(bandpass_inverse_q, 4'h3);
		`CHK(bandpass_q_off_recommended, 1'b1);
		chk_rd(8'h16, {4'h3, ~low});
		// module-off input follows one edge later, stop bit untouched
		for (int i = 0; i < 16; i++) begin
			off = 1'(xs());
			correction_module_off = off;
			@(negedge clock);
			`CHK(correction_enable, ~off);
			`CHK(correction_pulse_stop, v17[7]);
		end
		correction_module_off = 1'b0;
		// back-to-back write and read of every mapped place
		for (int a = 0; a < 4; a++) begin
			wv = 8'(xs());
			host.wr_rd(8'h16 + 8'(a), wv, rd_b, rd_v);
			`CHK(rd_v, 1'b1);
			`CHK(rd_b, wv);
		end
		// second reset in mid-run restores every default
		do_reset();
		final_report();
	end
endmodule : ripple_count_tuning_regs_tb
